// ---- ssba_asm_if.sv ----
// Byte to word assembly channel between the loader and its assembler
`timescale 1ns/1ps
interface ssba_asm_if;
    logic shift;
    logic clr;
    logic [7:0] byteIn;
    logic [31:0] word;
    logic [2:0] bytes;
    modport ctl (output shift, output clr, output byteIn, input word,
        input bytes);
    modport asm (input shift, input clr, input byteIn, output word,
        output bytes);
endinterface

// ---- ssba_cfg.svh ----
// Constants of the system services and boot block
// Behaviour
// R1: Rate pins give clock rate; 101, 111 invalid.
// R2: Reset fall starts bootstrap.
// R3: Link outputs low in reset.
// R4: Far side keeps inputs low, no DMA, in reset.
// R5: Boot source sampled once at reset fall.
// R6: ROM boot at top address, low priority.
// R7: Link boot ready two cycles after reset.
// R8: Control byte above one counts loaded bytes.
// R9: Other links keep messages after control byte.
// R10: Control byte zero pokes a word.
// R11: Control byte one peeks a word back.
// R12: Peek or poke returns to wait; same link.
// R13: Analyse halts at descheduling; refresh on.
// R14: Analysing: outputs fetch nothing new.
// R15: Analyse reset skips memory setup.
// R16: Analyse reset boots when analyse falls.
// R17: Reset after halt; analyse drops in reset.
// R18: Analyse loads I, W, descriptor, link.
// R19: Fault pin is error flag; reset keeps flags.
// R20: Error under stop flag halts; not reverse.
// R21: Pre-emption saves flags, clears stop flag.
// R22: Halt copies pointer plus two or one to A.
// R23: User memory base is 80000070.
`ifndef SSBA_CFG_SVH
`define SSBA_CFG_SVH
`define SSBA_NUM_LINKS 4
`define SSBA_ROM_START 32'h7fff_fffe
`define SSBA_USER_MEMORY_BASE 32'h8000_0070
`define SSBA_CTRL_POKE 8'h00
`define SSBA_CTRL_PEEK 8'h01
`define SSBA_ERR_IP_STEP 32'h0000_0002
`define SSBA_ANA_IP_STEP 32'h0000_0001
`define SSBA_WORD_MASK 32'hffff_fffc
`define SSBA_WORD_ROUND 32'h0000_0003
// Clock rate in tenths of MHz and cycle period in tenths of ns
`define SSBA_RATE_000 9'h0c8
`define SSBA_RATE_001 9'h0e1
`define SSBA_RATE_010 9'h0fa
`define SSBA_RATE_011 9'h12c
`define SSBA_RATE_100 9'h15e
`define SSBA_RATE_110 9'h0af
`define SSBA_PER_000 10'h1f4
`define SSBA_PER_001 10'h1bc
`define SSBA_PER_010 10'h190
`define SSBA_PER_011 10'h14d
`define SSBA_PER_100 10'h11e
`define SSBA_PER_110 10'h23b
`endif

// ---- ssba_link_peer.sv ----
// Peer processor on the links: sends queued bytes, gathers replies
`timescale 1ns/1ps
module ssba_link_peer(
    // Link ports
    input wire logic clk_sys,
    input wire logic [3:0] rxReady, txValid,
    input wire logic [7:0] txData,
    output logic [3:0] rxValid, txReady,
    output logic [31:0] rxData
);
    int lnk[$];
    logic [7:0] bq[$], got[$];
    logic stall = 0;
    initial rxValid = 4'h0;
    initial txReady = 4'h0;
    initial rxData = 32'h0;
    always @(posedge clk_sys)
    begin
        if (|(rxValid & rxReady))
        begin
            void'(bq.pop_front());
            void'(lnk.pop_front());
        end
        if (|(txValid & txReady))
            got.push_back(txData);
    end
    // Idle data toggles
    always @(negedge clk_sys)
    begin
        txReady <= stall ? 4'($urandom) : 4'hf;
        if (bq.size() != 0)
        begin
            rxValid <= 4'h1 << lnk[0];
            rxData <= 32'(bq[0]) << (8 * lnk[0]);
        end
        else
        begin
            rxValid <= 4'h0;
            rxData <= ~rxData;
        end
    end
endmodule

// ---- ssba_pkg.sv ----
// Types shared by the system services block
package ssba_pkg;
    typedef enum logic [3:0] {
        SSBA_RST = 4'b0000,
        SSBA_ANAWAIT = 4'b0001,
        SSBA_WAITCTRL = 4'b0010,
        SSBA_GETADDR = 4'b0011,
        SSBA_GETDATA = 4'b0100,
        SSBA_POKE = 4'b0101,
        SSBA_PEEK = 4'b0110,
        SSBA_SEND = 4'b0111,
        SSBA_LOAD = 4'b1000,
        SSBA_LOADWR = 4'b1001,
        SSBA_RUN = 4'b1010,
        SSBA_HALTED = 4'b1011
    } ssba_state_e;
    typedef struct packed {
        logic [31:0] word;
        logic [2:0] bytes;
    } ssba_asm_s;
endpackage

// ---- ssba_sys_asserts.sv ----
// Port-level assertions for the system services block
`timescale 1ns/1ps
module ssba_sys_asserts(
    // Watched ports
    input wire logic clk_sys, rst_b, devReset, analyseIn, rateValid,
    input wire logic [2:0] clockRateCodePins,
    input wire logic [3:0] txValid,
    input wire logic memCfgStart, errSet, testErr, hpReturn, halted,
    input wire logic hoeWrite, deschedPoint,
    input wire logic faultIndicatorPin, stopOnFaultFlag,
    input wire logic [31:0] instrPtr, regA
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_txLow; devReset |-> txValid == 4'h0; endproperty
    a_txLow: assert property (p_txLow) else $error("link out in reset");
    property p_rate;
        rateValid == !(clockRateCodePins inside {3'h5, 3'h7});
    endproperty
    a_rate: assert property (p_rate) else $error("rate valid wrong");
    property p_noCfg; analyseIn && $fell(devReset) |-> !memCfgStart [*4];
    endproperty
    a_noCfg: assert property (p_noCfg) else $error("config ran");
    property p_errKeep;
        !errSet && !testErr && !hpReturn |=> $stable(faultIndicatorPin);
    endproperty
    a_errKeep: assert property (p_errKeep) else $error("fault moved");
    property p_errSet; errSet |=> faultIndicatorPin; endproperty
    a_errSet: assert property (p_errSet) else $error("fault not set");
    property p_anaA;
        $rose(halted) && !faultIndicatorPin |-> regA == $past(instrPtr) + 32'h1;
    endproperty
    a_anaA: assert property (p_anaA) else $error("analyse pointer");
    property p_errHalt;
        errSet && !faultIndicatorPin && stopOnFaultFlag && !halted && !devReset
        |=> halted && regA == $past(instrPtr) + 32'h2;
    endproperty
    a_errHalt: assert property (p_errHalt) else $error("no error halt");
    property p_lateStop;
        hoeWrite && faultIndicatorPin && !halted && !analyseIn && !errSet &&
        !deschedPoint |=> !halted;
    endproperty
    a_lateStop: assert property (p_lateStop) else $error("late halt");
    property p_haltKeep; halted && !devReset |=> halted; endproperty
    a_haltKeep: assert property (p_haltKeep) else $error("left halt");
endmodule
bind ssba_system_services ssba_sys_asserts chk_u (.*);

// ---- ssba_system_services.sv ----
// Reset, boot source, peek and poke, analyse and error flag handling
`timescale 1ns/1ps
`include "ssba_cfg.svh"
module ssba_system_services
    import ssba_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Board control pins
    input wire logic devReset,
    input wire logic analyseIn,
    input wire logic bootSourceSelect,
    input wire logic [2:0] clockRateCodePins,
    // Clock rate decode
    output logic [8:0] rateTenthMhz,
    output logic [9:0] processorCyclePeriod,
    output logic rateValid,
    // Link bytes in
    input wire logic [3:0] rxValid,
    input wire logic [31:0] rxData,
    output logic [3:0] rxReady,
    // Link bytes out
    output logic [3:0] txValid,
    output logic [7:0] txData,
    input wire logic [3:0] txReady,
    // Link engine control
    output logic linkHoldMsg,
    output logic linkOutFetchEn,
    output logic linkInEn,
    // Memory access
    output logic memReq,
    output logic memWe,
    output logic [3:0] memBe,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    output logic memCfgStart,
    output logic refreshEn,
    // Processor side
    input wire logic deschedPoint,
    input wire logic [31:0] instrPtr,
    input wire logic [31:0] curWptr,
    input wire logic curPriority,
    input wire logic errSet,
    input wire logic testErr,
    input wire logic hoeWrite,
    input wire logic hoeValue,
    input wire logic hpPreempt,
    input wire logic hpReturn,
    // Start and halt state
    output logic runStart,
    output logic halted,
    output logic [31:0] regI,
    output logic [31:0] regW,
    output logic [31:0] regA,
    output logic [31:0] regB,
    output logic [31:0] regC,
    output logic startPriority,
    // Flags
    output logic faultIndicatorPin,
    output logic stopOnFaultFlag
);
    typedef struct packed {
        ssba_state_e st;
        logic resetPrev;
        logic anaPrev;
        logic anaPend;
        logic bootRom;
        logic anaReset;
        logic [1:0] linkSel;
        logic [7:0] cnt;
        logic [7:0] idx;
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0] txCnt;
        logic err;
        logic hoe;
        logic errSave;
        logic hoeSave;
        logic memReq;
        logic memWe;
        logic [3:0] memBe;
        logic [31:0] memAddr;
        logic [31:0] memWdata;
        logic [3:0] txValid;
        logic [7:0] txData;
        logic memCfgStart;
        logic refreshEn;
        logic runStart;
        logic startPri;
        logic [31:0] regI;
        logic [31:0] regW;
        logic [31:0] regA;
        logic [31:0] regB;
        logic [31:0] regC;
    } ssba_top_s;

    ssba_top_s s_q;
    ssba_top_s s_d;
    ssba_asm_if asmIf ();
    logic [3:0] rxAccept;
    logic [7:0] selByte;
    logic anyAccept;
    logic [1:0] firstLink;
    logic [7:0] firstByte;
    logic resetFall;
    logic anaRise;
    logic errRise;
    logic errNext;

    ssba_word_asm u_asm (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .a(asmIf.asm)
    );

    // Per-link input handshake
    genvar g;
    generate
        for (g = 0; g < `SSBA_NUM_LINKS; g++)
        begin : gLink
            always_comb
            begin
                if (devReset)
                begin
                    rxReady[g] = 1'b0;
                end
                else if (s_q.st == SSBA_WAITCTRL)
                begin
                    rxReady[g] = 1'b1; // R7
                end
                else if (s_q.st == SSBA_GETADDR || s_q.st == SSBA_GETDATA ||
                    s_q.st == SSBA_LOAD)
                begin
                    rxReady[g] = (s_q.linkSel == 2'(g)); // R12
                end
                else
                begin
                    rxReady[g] = 1'b0;
                end
            end
            assign rxAccept[g] = rxValid[g] & rxReady[g];
        end
    endgenerate

    // Lowest numbered link wins a tie on the control byte
    always_comb
    begin
        firstLink = 2'h0;
        for (int i = `SSBA_NUM_LINKS - 1; i >= 0; i--)
        begin
            if (rxAccept[i])
            begin
                firstLink = 2'(i);
            end
        end
        firstByte = rxData[{firstLink, 3'h0} +: 8];
    end

    assign anyAccept = |rxAccept;
    assign selByte = rxData[{s_q.linkSel, 3'h0} +: 8];
    assign resetFall = s_q.resetPrev & ~devReset; // R2
    assign anaRise = analyseIn & ~s_q.anaPrev;
    assign errRise = errSet & ~s_q.err;
    // Set wins over test-and-clear
    assign errNext = (s_q.err & ~testErr) | errSet; // R19

    assign asmIf.shift = anyAccept && (s_q.st == SSBA_GETADDR ||
        s_q.st == SSBA_GETDATA);
    assign asmIf.clr = (s_q.st == SSBA_WAITCTRL) || (s_q.st == SSBA_POKE) ||
        (asmIf.shift && asmIf.bytes == 3'h3 && s_q.st == SSBA_GETADDR &&
        s_q.data[0] == 1'b0);
    assign asmIf.byteIn = selByte;

    always_comb
    begin
        s_d = s_q;
        s_d.resetPrev = devReset;
        s_d.anaPrev = analyseIn;
        s_d.memCfgStart = 1'b0;
        s_d.runStart = 1'b0;
        // Error and stop flags are never touched by devReset
        s_d.err = errNext;
        if (hoeWrite)
        begin
            s_d.hoe = hoeValue;
        end
        if (hpPreempt)
        begin
            s_d.errSave = errNext; // R21
            s_d.hoeSave = s_q.hoe;
            s_d.hoe = 1'b0;
        end
        else if (hpReturn)
        begin
            s_d.err = s_q.errSave | errSet;
            s_d.hoe = s_q.hoeSave;
        end
        if (devReset)
        begin
            s_d.st = SSBA_RST;
            s_d.txValid = 4'h0; // R3
            s_d.memReq = 1'b0;
            s_d.anaPend = 1'b0;
        end
        else
        begin
            case (s_q.st)
                SSBA_RST:
                begin
                    if (resetFall)
                    begin
                        s_d.bootRom = bootSourceSelect; // R5
                        s_d.anaReset = analyseIn;
                        s_d.refreshEn = 1'b1;
                        // Memory setup kept from before an analyse reset
                        s_d.memCfgStart = ~analyseIn; // R15
                        if (analyseIn)
                        begin
                            s_d.st = SSBA_ANAWAIT;
                        end
                        else if (bootSourceSelect)
                        begin
                            s_d.st = SSBA_RUN; // R6
                            s_d.runStart = 1'b1;
                            s_d.startPri = 1'b1;
                            s_d.regI = `SSBA_ROM_START;
                            s_d.regW = `SSBA_USER_MEMORY_BASE; // R23
                        end
                        else
                        begin
                            s_d.st = SSBA_WAITCTRL;
                        end
                    end
                end
                SSBA_ANAWAIT:
                begin
                    if (!analyseIn)
                    begin
                        if (s_q.bootRom)
                        begin
                            s_d.st = SSBA_RUN; // R16
                            s_d.runStart = 1'b1;
                            s_d.startPri = 1'b1;
                            s_d.regI = `SSBA_ROM_START; // R18
                            s_d.regW = `SSBA_USER_MEMORY_BASE;
                        end
                        else
                        begin
                            s_d.st = SSBA_WAITCTRL; // R16
                        end
                    end
                end
                SSBA_WAITCTRL:
                begin
                    if (anyAccept)
                    begin
                        s_d.linkSel = firstLink;
                        s_d.data = {24'h00_0000, firstByte};
                        if (firstByte == `SSBA_CTRL_POKE ||
                            firstByte == `SSBA_CTRL_PEEK)
                        begin
                            s_d.st = SSBA_GETADDR; // R10 R11
                        end
                        else
                        begin
                            s_d.cnt = firstByte; // R8
                            s_d.idx = 8'h00;
                            s_d.st = SSBA_LOAD;
                        end
                    end
                end
                SSBA_GETADDR:
                begin
                    if (asmIf.shift && asmIf.bytes == 3'h3)
                    begin
                        s_d.addr = {selByte, asmIf.word[31:8]};
                        if (s_q.data[0])
                        begin
                            s_d.st = SSBA_PEEK; // R11
                            s_d.memReq = 1'b1;
                            s_d.memWe = 1'b0;
                            s_d.memBe = 4'hf;
                            s_d.memAddr = {selByte, asmIf.word[31:8]};
                        end
                        else
                        begin
                            s_d.st = SSBA_GETDATA; // R10
                        end
                    end
                end
                SSBA_GETDATA:
                begin
                    if (asmIf.shift && asmIf.bytes == 3'h3)
                    begin
                        s_d.st = SSBA_POKE;
                        s_d.memReq = 1'b1;
                        s_d.memWe = 1'b1;
                        s_d.memBe = 4'hf;
                        s_d.memAddr = s_q.addr;
                        s_d.memWdata = {selByte, asmIf.word[31:8]};
                    end
                end
                SSBA_POKE:
                begin
                    if (memAck)
                    begin
                        s_d.memReq = 1'b0;
                        s_d.st = SSBA_WAITCTRL; // R12
                    end
                end
                SSBA_PEEK:
                begin
                    if (memAck)
                    begin
                        s_d.memReq = 1'b0;
                        s_d.data = memRdata;
                        s_d.txCnt = 2'h0;
                        s_d.txData = memRdata[7:0];
                        s_d.txValid = 4'h1 << s_q.linkSel; // R11
                        s_d.st = SSBA_SEND;
                    end
                end
                SSBA_SEND:
                begin
                    if (|(s_q.txValid & txReady))
                    begin
                        if (s_q.txCnt == 2'h3)
                        begin
                            s_d.txValid = 4'h0;
                            s_d.st = SSBA_WAITCTRL; // R12
                        end
                        else
                        begin
                            s_d.txCnt = s_q.txCnt + 2'h1;
                            s_d.data = {8'h00, s_q.data[31:8]};
                            s_d.txData = s_q.data[15:8];
                        end
                    end
                end
                SSBA_LOAD:
                begin
                    if (anyAccept)
                    begin
                        s_d.memAddr = `SSBA_USER_MEMORY_BASE +
                            {24'h00_0000, s_q.idx}; // R8
                        s_d.memBe = 4'h1 << s_d.memAddr[1:0];
                        s_d.memWdata = {4{selByte}};
                        s_d.memReq = 1'b1;
                        s_d.memWe = 1'b1;
                        s_d.st = SSBA_LOADWR;
                    end
                end
                SSBA_LOADWR:
                begin
                    if (memAck)
                    begin
                        s_d.memReq = 1'b0;
                        s_d.idx = s_q.idx + 8'h01;
                        if (s_q.idx + 8'h01 == s_q.cnt)
                        begin
                            s_d.st = SSBA_RUN; // R8
                            s_d.runStart = 1'b1;
                            s_d.startPri = 1'b1;
                            s_d.regI = `SSBA_USER_MEMORY_BASE; // R18
                            // Workspace is the first free word after the code
                            s_d.regW = (`SSBA_USER_MEMORY_BASE +
                                {24'h00_0000, s_q.cnt} + `SSBA_WORD_ROUND) &
                                `SSBA_WORD_MASK;
                            s_d.regC = {30'h0000_0000, s_q.linkSel}; // R18
                        end
                        else
                        begin
                            s_d.st = SSBA_LOAD;
                        end
                    end
                end
                SSBA_RUN:
                begin
                    if (anaRise)
                    begin
                        s_d.anaPend = 1'b1; // R13
                    end
                    if (errRise && s_q.hoe)
                    begin
                        s_d.st = SSBA_HALTED; // R20
                        s_d.regA = instrPtr + `SSBA_ERR_IP_STEP; // R22
                        s_d.regB = {curWptr[31:1], curPriority};
                    end
                    else if ((s_q.anaPend || anaRise) && deschedPoint)
                    begin
                        s_d.st = SSBA_HALTED; // R13
                        s_d.regA = instrPtr + `SSBA_ANA_IP_STEP; // R22
                        s_d.regB = {curWptr[31:1], curPriority}; // R18
                    end
                end
                SSBA_HALTED:
                begin
                    // Left only through a reset pulse
                    s_d.anaPend = 1'b0;
                end
                default:
                begin
                    s_d.st = SSBA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Rate decode is combinational from strapped pins
    always_comb
    begin
        rateValid = 1'b1; // R1
        case (clockRateCodePins)
            3'h0:
            begin
                rateTenthMhz = `SSBA_RATE_000;
                processorCyclePeriod = `SSBA_PER_000;
            end
            3'h1:
            begin
                rateTenthMhz = `SSBA_RATE_001;
                processorCyclePeriod = `SSBA_PER_001;
            end
            3'h2:
            begin
                rateTenthMhz = `SSBA_RATE_010;
                processorCyclePeriod = `SSBA_PER_010;
            end
            3'h3:
            begin
                rateTenthMhz = `SSBA_RATE_011;
                processorCyclePeriod = `SSBA_PER_011;
            end
            3'h4:
            begin
                rateTenthMhz = `SSBA_RATE_100;
                processorCyclePeriod = `SSBA_PER_100;
            end
            3'h6:
            begin
                rateTenthMhz = `SSBA_RATE_110;
                processorCyclePeriod = `SSBA_PER_110;
            end
            default:
            begin
                rateValid = 1'b0;
                rateTenthMhz = 9'h000;
                processorCyclePeriod = 10'h000;
            end
        endcase
    end

    assign txValid = s_q.txValid;
    assign txData = s_q.txData;
    // Other links keep their bytes once a control byte has chosen one
    assign linkHoldMsg = (s_q.st != SSBA_RST) && (s_q.st != SSBA_ANAWAIT) &&
        (s_q.st != SSBA_WAITCTRL); // R9
    // No new memory fetch for output once a halt is pending
    assign linkOutFetchEn = (s_q.st == SSBA_RUN) && !s_q.anaPend; // R14
    assign linkInEn = !devReset; // R14
    assign memReq = s_q.memReq;
    assign memWe = s_q.memWe;
    assign memBe = s_q.memBe;
    assign memAddr = s_q.memAddr;
    assign memWdata = s_q.memWdata;
    assign memCfgStart = s_q.memCfgStart;
    assign refreshEn = s_q.refreshEn; // R13
    assign runStart = s_q.runStart;
    assign halted = (s_q.st == SSBA_HALTED);
    assign regI = s_q.regI;
    assign regW = s_q.regW;
    assign regA = s_q.regA;
    assign regB = s_q.regB;
    assign regC = s_q.regC;
    assign startPriority = s_q.startPri;
    assign faultIndicatorPin = s_q.err; // R19
    assign stopOnFaultFlag = s_q.hoe;
endmodule

// ---- ssba_word_asm.sv ----
// Assembles link bytes into a word, least significant byte first
`timescale 1ns/1ps
module ssba_word_asm
    import ssba_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Byte channel
    ssba_asm_if.asm a
);
    ssba_asm_s s_q;
    ssba_asm_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (a.clr)
        begin
            s_d.word = 32'h0000_0000;
            s_d.bytes = 3'h0;
        end
        else if (a.shift)
        begin
            // First byte ends in the low lane after four shifts
            s_d.word = {a.byteIn, s_q.word[31:8]};
            s_d.bytes = s_q.bytes + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign a.word = s_q.word;
    assign a.bytes = s_q.bytes;
endmodule

// ---- system_services_boot_analyse_tb.sv ----
// Self-checking bench for the system services block
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((e) !== (g)) begin \
    $display("BAD %s exp %h got %h", n, e, g); failures++; end end
`define WAITN(c) for (k = 0; k < 400 && !(c); k++) @(negedge clk_sys);
`define PULSE(s) begin s = 1; @(negedge clk_sys); s = 0; end
module system_services_boot_analyse_tb;
    logic clk_sys = 0, rst_b = 0, devReset = 1, analyseIn = 0;
    logic bootSourceSelect = 0, memAck = 0, deschedPoint = 0, curPriority = 1;
    logic errSet = 0, testErr = 0, hoeWrite = 0, hoeValue = 0;
    logic hpPreempt = 0, hpReturn = 0, rateValid, memCfgStart, refreshEn;
    logic memReq, memWe, linkHoldMsg, linkOutFetchEn, linkInEn, runStart;
    logic halted, startPriority, faultIndicatorPin, stopOnFaultFlag;
    logic [2:0] clockRateCodePins = 3'h0;
    logic [3:0] rxValid, rxReady, txValid, txReady, memBe;
    logic [7:0] txData, b0;
    logic [8:0] rateTenthMhz;
    logic [9:0] processorCyclePeriod;
    logic [31:0] rxData, memAddr, memWdata, memRdata = 32'h0, instrPtr = 0;
    logic [31:0] curWptr = 0, regI, regW, regA, regB, regC, a, d;
    logic [31:0] mem[logic [29:0]];
    logic [31:0] ub = 32'h8000_0070;
    int k, c, failures = 0, numChecks = 0, cyc = 0;
    int rt[8] = '{200, 225, 250, 300, 350, 0, 175, 0};
    ssba_system_services dut_u (.*);
    ssba_link_peer pr (.*);
    initial forever #5 clk_sys = ~clk_sys;
    always @(negedge clk_sys)
    begin
        memAck <= 0;
        if (memReq && !memAck && $urandom_range(1, 0))
        begin
            memAck <= 1;
            memRdata <= mem[memAddr[31:2]];
            for (int i = 0; i < 4; i++)
                if (memWe && memBe[i])
                    mem[memAddr[31:2]][8*i+:8] = memWdata[8*i+:8];
        end
    end
    always @(posedge clk_sys)
        if (++cyc == 20000)
        begin
            failures++;
            final_report;
        end
    task automatic snd(int l, logic [7:0] v);
        pr.lnk.push_back(l);
        pr.bq.push_back(v);
    endtask
    task automatic sndw(int l, logic [31:0] v);
        for (int i = 0; i < 4; i++)
            snd(l, v[8*i+:8]);
    endtask
    task automatic devPulse;
        devReset = 1;
        repeat (3) @(negedge clk_sys);
        devReset = 0;
    endtask
    task final_report;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        k = $urandom(4305);
        repeat (20) @(negedge clk_sys);
        rst_b = 1;
        for (c = 0; c < 8; c++)
        begin
            clockRateCodePins = c[2:0];
            #1 `CHK("rate", 9'(rt[c]), rateTenthMhz)
            `CHK("rateOk", rt[c] != 0, rateValid)
            `CHK("per", 10'(rt[c] ? (100000 + rt[c] / 2) / rt[c] : 0), processorCyclePeriod)
            @(negedge clk_sys);
        end
        $display("rates done");
        devReset = 0;
        a = $urandom & 32'hffff_fffc;
        d = $urandom;
        snd(2, 8'h00);
        sndw(2, a);
        sndw(2, d);
        `WAITN(pr.bq.size() == 0)
        repeat (20) @(negedge clk_sys);
        `CHK("poke", d, mem[a[31:2]])
        pr.stall = 1;
        snd(1, 8'h01);
        sndw(1, a);
        `WAITN(pr.got.size() == 4)
        `CHK("peek", d, {pr.got[3], pr.got[2], pr.got[1], pr.got[0]})
        b0 = $urandom;
        snd(3, 8'h06);
        snd(3, b0);
        repeat (5) snd(3, 8'($urandom));
        `WAITN(runStart)
        `CHK("loadI", ub, regI)
        `CHK("loadW", (ub + 32'h9) & 32'hffff_fffc, regW)
        `CHK("loadC", 32'h3, regC)
        `CHK("loadB", b0, mem[ub[31:2]][7:0])
        $display("link boot done");
        instrPtr = $urandom;
        curWptr = $urandom;
        analyseIn = 1;
        @(negedge clk_sys);
        `PULSE(deschedPoint)
        `WAITN(halted)
        `CHK("anaA", instrPtr + 32'h1, regA)
        `CHK("anaB", {curWptr[31:1], 1'b1}, regB)
        bootSourceSelect = 1;
        devPulse;
        repeat (6) @(negedge clk_sys);
        `CHK("held", 1'b0, runStart)
        analyseIn = 0;
        `WAITN(runStart)
        `CHK("romI", 32'h7fff_fffe, regI)
        `CHK("romW", ub, regW)
        `CHK("romP", 1'b1, startPriority)
        $display("analyse done");
        hoeValue = 1;
        `PULSE(hoeWrite)
        `PULSE(errSet)
        `WAITN(halted)
        `CHK("errA", instrPtr + 32'h2, regA)
        devPulse;
        repeat (4) @(negedge clk_sys);
        `CHK("errKeep", 1'b1, faultIndicatorPin)
        `CHK("stopKeep", 1'b1, stopOnFaultFlag)
        `PULSE(testErr)
        `CHK("errClr", 1'b0, faultIndicatorPin)
        hoeValue = 0;
        `PULSE(hoeWrite)
        `PULSE(errSet)
        hoeValue = 1;
        `PULSE(hoeWrite)
        repeat (3) @(negedge clk_sys);
        `CHK("noHalt", 1'b0, halted)
        `PULSE(hpPreempt)
        `CHK("hpStop", 1'b0, stopOnFaultFlag)
        `CHK("hpErr", 1'b1, faultIndicatorPin)
        `PULSE(hpReturn)
        `CHK("hpBack", 1'b1, stopOnFaultFlag)
        $display("error flags done");
        final_report;
    end
endmodule
